/* File: hdl/cds_selector.sv */
`timescale 1ns/1ns
`include "cds_consts.svh"

module cds_selector
    import cds_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `CDS_HOLD_MS * `CDS_CLK_KHZ,
    parameter int unsigned TICK_CYCLES = `CDS_ACK_TICK_MS * `CDS_CLK_KHZ
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Operator button and system events, asynchronous pins.
    input  wire logic        toggle_btn,
    input  wire logic        first_boot,
    input  wire logic        fw_upgrade_done,
    // Effective channel zero configuration.
    output logic [2:0]       ch0_baud_sel,
    output logic             ch0_parity_even,
    output logic [7:0]       ch0_node_addr,
    output logic             ch0_modem_hs,
    output logic             ch0_err_bcc,
    output logic             ch0_embed_en,
    output logic             ch0_dup_det,
    output logic [15:0]      ch0_ack_timeout,
    output logic [7:0]       ch0_nak_retries,
    output logic [7:0]       ch0_enq_retries,
    output logic [1:0]       ch0_stop_bits,
    output logic             ack_count_tick,
    // Indicator.
    output logic             default_comms_indicator
);

    // Synchroniser stages for the three pins, upgrade edge history and boot count.
    logic [2:0]  pin_meta_reg;
    logic [2:0]  pin_sync_reg;
    logic        upg_prev_reg;
    logic [1:0]  boot_cnt_reg;

    // Button timing.
    cds_btn_e    btn_state_reg;
    logic [26:0] hold_cnt_reg;
    logic        press_ok;

    // Configuration state.
    logic        dflt_reg;
    logic [15:0] cfg_reg;
    logic [15:0] timeout_reg;
    logic [15:0] retry_reg;
    logic        reject_reg;

    // Bus pipeline and timeout tick counter.
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic        addr_ok;
    logic [31:0] rd_mux;
    logic [19:0] tick_cnt_reg;

    // Two flops on every pin before any logic looks at it.
    // The pins idle low, so clearing both stages in reset raises no false edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {fw_upgrade_done, first_boot, toggle_btn};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Edge history of the upgrade level and a short count after reset release.
    // The boot strap is read only once the synchroniser has filled.
    // An upgrade level still high across a reset counts as a fresh edge and
    // forces the defaults again, which is the safe side to err on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upg_prev_reg <= 1'b0;
            boot_cnt_reg <= 2'h0;
        end else begin
            upg_prev_reg <= pin_sync_reg[2];
            if (boot_cnt_reg != 2'h3) begin
                boot_cnt_reg <= boot_cnt_reg + 2'h1;
            end
        end
    end

    // Hold timer: counts while the button stays pressed, fires once per press.
    // Twenty-seven bits cover two seconds at 50 MHz with some headroom.
    // A press that outlasts the hold waits for release before it can re-arm.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            btn_state_reg <= CDS_BTN_IDLE;
            hold_cnt_reg  <= 27'h0;
        end else begin
            unique case (btn_state_reg)
                CDS_BTN_IDLE: begin
                    hold_cnt_reg <= 27'h0;
                    if (pin_sync_reg[0]) begin
                        btn_state_reg <= CDS_BTN_HOLD;
                    end
                end
                CDS_BTN_HOLD: begin
                    if (!pin_sync_reg[0]) begin
                        // Early release throws the press away.
                        btn_state_reg <= CDS_BTN_IDLE;
                        hold_cnt_reg  <= 27'h0;
                    end else if (press_ok) begin
                        btn_state_reg <= CDS_BTN_WAIT;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + 27'h1;
                    end
                end
                CDS_BTN_WAIT: begin
                    // A long hold toggles only once; release re-arms.
                    if (!pin_sync_reg[0]) begin
                        btn_state_reg <= CDS_BTN_IDLE;
                    end
                end
                default: begin
                    btn_state_reg <= CDS_BTN_IDLE;
                end
            endcase
        end
    end

    // Fires in the cycle the hold reaches two seconds of pressed samples.
    assign press_ok = (btn_state_reg == CDS_BTN_HOLD) && pin_sync_reg[0]
                      && (hold_cnt_reg == 27'(HOLD_CYCLES - 1));

    // Active set selection. Forced events win over a toggle in the same cycle,
    // since they must leave the device on defaults.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dflt_reg <= 1'b0;
        end else if (boot_cnt_reg == 2'h2 && pin_sync_reg[1]) begin
            dflt_reg <= 1'b1;
        end else if (pin_sync_reg[2] && !upg_prev_reg) begin
            dflt_reg <= 1'b1;
        end else if (press_ok) begin
            dflt_reg <= ~dflt_reg;
        end
    end

    // Range checks for write data.
    // A refused value leaves the register alone and sets the sticky flag,
    // so software can tell that its write had no effect.
    logic wr_now;
    logic cfg_bad;
    logic to_bad;
    assign wr_now  = wr_pend_reg;
    assign cfg_bad = (wr_addr_reg == `CDS_OFS_CFG)
                     && (hwdata[`CDS_CFG_NODE_LSB +: 8] > `CDS_NODE_MAX);
    assign to_bad  = (wr_addr_reg == `CDS_OFS_TIMEOUT) && (hwdata[15:0] == 16'h0000);

    // User set registers; an out-of-range write keeps the old value.
    // Every three-bit baud code is a listed rate, so no code is refused.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg     <= {`CDS_DEF_NODE, 8'h80 | {5'h0, `CDS_DEF_BAUD}};
            timeout_reg <= `CDS_DEF_ACK_TO;
            retry_reg   <= {`CDS_DEF_RETRIES, `CDS_DEF_RETRIES};
        end else if (wr_now) begin
            if (wr_addr_reg == `CDS_OFS_CFG && !cfg_bad) begin
                cfg_reg <= hwdata[15:0];
            end
            if (wr_addr_reg == `CDS_OFS_TIMEOUT && !to_bad) begin
                timeout_reg <= hwdata[15:0];
            end
            if (wr_addr_reg == `CDS_OFS_RETRY) begin
                retry_reg <= hwdata[15:0];
            end
        end
    end

    // Sticky rejected-write flag; a new rejection beats a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reject_reg <= 1'b0;
        end else if (wr_now && (cfg_bad || to_bad)) begin
            reject_reg <= 1'b1;
        end else if (wr_now && wr_addr_reg == `CDS_OFS_STATUS
                     && hwdata[`CDS_ST_REJECT]) begin
            reject_reg <= 1'b0;
        end
    end

    // Effective channel zero settings, registered straight to the pins.
    // All of this channel's outputs except the fixed stop bits follow the toggle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch0_baud_sel    <= `CDS_DEF_BAUD;
            ch0_parity_even <= 1'b0;
            ch0_node_addr   <= `CDS_DEF_NODE;
            ch0_modem_hs    <= 1'b0;
            ch0_err_bcc     <= 1'b0;
            ch0_embed_en    <= 1'b0;
            ch0_dup_det     <= 1'b1;
            ch0_ack_timeout <= `CDS_DEF_ACK_TO;
            ch0_nak_retries <= `CDS_DEF_RETRIES;
            ch0_enq_retries <= `CDS_DEF_RETRIES;
            ch0_stop_bits   <= `CDS_STOP_BITS;
        end else if (dflt_reg) begin
            ch0_baud_sel    <= CDS_BAUD_19K2;
            ch0_parity_even <= 1'b0;
            ch0_node_addr   <= `CDS_DEF_NODE;
            ch0_modem_hs    <= 1'b0;
            ch0_err_bcc     <= 1'b0;
            ch0_embed_en    <= 1'b0;
            ch0_dup_det     <= 1'b1;
            ch0_ack_timeout <= `CDS_DEF_ACK_TO;
            ch0_nak_retries <= `CDS_DEF_RETRIES;
            ch0_enq_retries <= `CDS_DEF_RETRIES;
            ch0_stop_bits   <= `CDS_STOP_BITS;
        end else begin
            ch0_baud_sel    <= cfg_reg[`CDS_CFG_BAUD_LSB +: 3];
            ch0_parity_even <= cfg_reg[`CDS_CFG_PARITY];
            ch0_node_addr   <= cfg_reg[`CDS_CFG_NODE_LSB +: 8];
            ch0_modem_hs    <= cfg_reg[`CDS_CFG_MODEM_HS];
            ch0_err_bcc     <= cfg_reg[`CDS_CFG_ERR_BCC];
            ch0_embed_en    <= cfg_reg[`CDS_CFG_EMBED_EN];
            ch0_dup_det     <= cfg_reg[`CDS_CFG_DUP_DET];
            ch0_ack_timeout <= timeout_reg;
            ch0_nak_retries <= retry_reg[7:0];
            ch0_enq_retries <= retry_reg[`CDS_RETRY_ENQ_LSB +: 8];
            ch0_stop_bits   <= `CDS_STOP_BITS;
        end
    end

    // Indicator mirrors the active set.
    // One flop of lag keeps the lamp in step with the channel outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            default_comms_indicator <= 1'b0;
        end else begin
            default_comms_indicator <= dflt_reg;
        end
    end

    // One-cycle enable every 20 ms, the unit of the acknowledge timeout.
    // It runs free from reset from zero, so the first tick comes one full period after start-up.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg   <= 20'h0;
            ack_count_tick <= 1'b0;
        end else if (tick_cnt_reg == 20'(TICK_CYCLES - 1)) begin
            tick_cnt_reg   <= 20'h0;
            ack_count_tick <= 1'b1;
        end else begin
            tick_cnt_reg   <= tick_cnt_reg + 20'h1;
            ack_count_tick <= 1'b0;
        end
    end

    // Address phase decode; every access is accepted with no wait state.
    // Size and the sequential bit are not decoded: only whole-word single
    // transfers are supported, and a narrower write still lands as a word.
    assign addr_ok = hsel && hready && htrans[1];

    // Read mux evaluated in the address phase so data is ready in the data phase.
    always_comb begin
        rd_mux = 32'h0;
        unique case (haddr)
            `CDS_OFS_CFG:     rd_mux = {16'h0, cfg_reg};
            `CDS_OFS_TIMEOUT: rd_mux = {16'h0, timeout_reg};
            `CDS_OFS_RETRY:   rd_mux = {16'h0, retry_reg};
            `CDS_OFS_STATUS:  rd_mux = {29'h0, (btn_state_reg == CDS_BTN_HOLD),
                                        reject_reg, dflt_reg};
            default:          rd_mux = 32'h0;
        endcase
    end

    // Bus pipeline registers. A read right after a write to the same
    // register returns the value before that write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_reg <= haddr;
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

endmodule

/* File: hdl/cds_consts.svh */
`ifndef CDS_CONSTS_SVH
`define CDS_CONSTS_SVH

// Clock rate and documented times.
`define CDS_CLK_KHZ        50000
`define CDS_HOLD_MS        2000
`define CDS_ACK_TICK_MS    20

// Register byte offsets.
`define CDS_OFS_CFG        8'h00
`define CDS_OFS_TIMEOUT    8'h04
`define CDS_OFS_RETRY      8'h08
`define CDS_OFS_STATUS     8'h0C

// Field positions in the CFG and RETRY registers.
`define CDS_CFG_BAUD_LSB   0
`define CDS_CFG_PARITY     3
`define CDS_CFG_MODEM_HS   4
`define CDS_CFG_ERR_BCC    5
`define CDS_CFG_EMBED_EN   6
`define CDS_CFG_DUP_DET    7
`define CDS_CFG_NODE_LSB   8
`define CDS_RETRY_ENQ_LSB  8

// Field positions in the STATUS register.
`define CDS_ST_DEFAULT     0
`define CDS_ST_REJECT      1
`define CDS_ST_HOLDING     2

// Default set and limits.
`define CDS_DEF_BAUD       3'h6
`define CDS_DEF_NODE       8'h01
`define CDS_DEF_ACK_TO     16'h0032
`define CDS_DEF_RETRIES    8'h03
`define CDS_NODE_MAX       8'hFE
`define CDS_STOP_BITS      2'h1

`endif

/* File: hdl/cds_pkg.sv */
package cds_pkg;

    // Baud rate selector codes; all eight codes are legal rates.
    typedef enum logic [2:0] {
        CDS_BAUD_300   = 3'h0,
        CDS_BAUD_600   = 3'h1,
        CDS_BAUD_1200  = 3'h2,
        CDS_BAUD_2400  = 3'h3,
        CDS_BAUD_4800  = 3'h4,
        CDS_BAUD_9600  = 3'h5,
        CDS_BAUD_19K2  = 3'h6,
        CDS_BAUD_38K4  = 3'h7
    } cds_baud_e;

    // Button hold state machine, one-hot.
    typedef enum logic [2:0] {
        CDS_BTN_IDLE = 3'h1,
        CDS_BTN_HOLD = 3'h2,
        CDS_BTN_WAIT = 3'h4
    } cds_btn_e;

endpackage

/* File: tb/cds_selector_asserts.sv */
`timescale 1ns/1ns

module cds_selector_chk #(
    parameter int unsigned HOLD_CYCLES = 20,
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus response.
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Button and system events.
    input wire logic        toggle_btn,
    input wire logic        first_boot,
    input wire logic        fw_upgrade_done,
    // Channel zero outputs.
    input wire logic [2:0]  ch0_baud_sel,
    input wire logic [7:0]  ch0_node_addr,
    input wire logic [15:0] ch0_ack_timeout,
    input wire logic [1:0]  ch0_stop_bits,
    input wire logic        ack_count_tick,
    input wire logic        default_comms_indicator
);
    logic [15:0] press_len;
    logic [3:0]  quiet_cnt;
    logic [7:0]  tick_gap;
    logic        tick_seen;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Length of the current press, saturating so a stuck button cannot wrap.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) press_len <= 16'h0000;
        else if (!toggle_btn) press_len <= 16'h0000;
        else if (press_len != 16'hFFFF) press_len <= press_len + 16'h0001;
    end

    // Quiet time since a forced default; forced changes are not button changes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) quiet_cnt <= 4'h0;
        else if (first_boot || fw_upgrade_done) quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hF) quiet_cnt <= quiet_cnt + 4'h1;
    end

    // Cycles since the previous timeout tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_gap  <= 8'h00;
            tick_seen <= 1'b0;
        end else begin
            tick_gap  <= ack_count_tick ? 8'h00 : tick_gap + 8'h01;
            tick_seen <= tick_seen | ack_count_tick;
        end
    end

    sequence ind_steady;
        $stable(default_comms_indicator) [*6];
    endsequence

    stop_bits_fixed_a: assert property (ch0_stop_bits == 2'h1)
        else $error("stop bit count is not one");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus response is not ready and okay");
    default_shown_a: assert property (default_comms_indicator |-> ch0_baud_sel == 3'h6 &&
        ch0_node_addr == 8'h01 && ch0_ack_timeout == 16'h0032)
        else $error("indicator lit without the default set");
    hold_time_a: assert property ($changed(default_comms_indicator) && quiet_cnt == 4'hF
        |-> $past(press_len, 2) >= HOLD_CYCLES) else $error("toggle taken before hold time");
    short_press_a: assert property ($fell(toggle_btn) && press_len < HOLD_CYCLES - 4
        && quiet_cnt == 4'hF |=> ind_steady) else $error("short press changed the set");
    upgrade_force_a: assert property ($rose(fw_upgrade_done) |-> ##[1:8] default_comms_indicator)
        else $error("upgrade did not force defaults");
    boot_force_a: assert property ($rose(hresetn) && first_boot |-> ##[2:8] default_comms_indicator)
        else $error("first power-up did not force defaults");
    tick_period_a: assert property (ack_count_tick && tick_seen |-> tick_gap == TICK_CYCLES - 1)
        else $error("timeout tick period wrong");
endmodule

bind cds_selector cds_selector_chk #(.HOLD_CYCLES(HOLD_CYCLES), .TICK_CYCLES(TICK_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .toggle_btn(toggle_btn), .first_boot(first_boot), .fw_upgrade_done(fw_upgrade_done),
    .ch0_baud_sel(ch0_baud_sel), .ch0_node_addr(ch0_node_addr),
    .ch0_ack_timeout(ch0_ack_timeout), .ch0_stop_bits(ch0_stop_bits),
    .ack_count_tick(ack_count_tick), .default_comms_indicator(default_comms_indicator));

/* File: tb/cds_button_model.sv */
`timescale 1ns/1ns

module cds_button_model (
    // Clock and watched indicator.
    input  wire logic hclk,
    input  wire logic default_comms_indicator,
    // Button pin.
    output logic      toggle_btn
);
    initial toggle_btn = 1'b0;

    // Short press, then a pause long enough for the pin to re-arm.
    task tap(input int n);
        @(posedge hclk) toggle_btn <= 1'b1;
        repeat (n) @(posedge hclk);
        toggle_btn <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask

    // Operator holds until the lamp changes; the limit stops a dead device hanging us.
    task hold(input int lim, output int took);
        logic start;
        start = default_comms_indicator;
        took = 0;
        @(posedge hclk) toggle_btn <= 1'b1;
        while (default_comms_indicator === start && took < lim) begin
            @(posedge hclk);
            took++;
        end
        toggle_btn <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
endmodule

/* File: tb/tb_comm_default_config_selector.sv */
`timescale 1ns/1ns

module tb_comm_default_config_selector;
    localparam int unsigned HOLD = 20;
    localparam logic [47:0] DEF_SET = 48'hC011_0032_0303;
    localparam logic [47:0] USR_SET = 48'hF05E_FFFF_070A;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr, ch0_node_addr, ch0_nak_retries, ch0_enq_retries;
    logic [1:0]  htrans, ch0_stop_bits;
    logic [2:0]  hsize, ch0_baud_sel;
    logic [31:0] hwdata, hrdata, rd;
    logic        toggle_btn, first_boot, fw_upgrade_done, ack_count_tick;
    logic        ch0_parity_even, ch0_modem_hs, ch0_err_bcc, ch0_embed_en, ch0_dup_det;
    logic        default_comms_indicator;
    logic [15:0] ch0_ack_timeout;
    logic [47:0] cfg_now;
    int          errors, cmp_count, cyc, took, ticks;

    assign cfg_now = {ch0_baud_sel, ch0_parity_even, ch0_node_addr, ch0_modem_hs, ch0_err_bcc,
                      ch0_embed_en, ch0_dup_det, ch0_ack_timeout, ch0_nak_retries, ch0_enq_retries};

    cds_selector #(.HOLD_CYCLES(HOLD), .TICK_CYCLES(10)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .toggle_btn(toggle_btn),
        .first_boot(first_boot), .fw_upgrade_done(fw_upgrade_done),
        .ch0_baud_sel(ch0_baud_sel), .ch0_parity_even(ch0_parity_even),
        .ch0_node_addr(ch0_node_addr), .ch0_modem_hs(ch0_modem_hs), .ch0_err_bcc(ch0_err_bcc),
        .ch0_embed_en(ch0_embed_en), .ch0_dup_det(ch0_dup_det),
        .ch0_ack_timeout(ch0_ack_timeout), .ch0_nak_retries(ch0_nak_retries),
        .ch0_enq_retries(ch0_enq_retries), .ch0_stop_bits(ch0_stop_bits),
        .ack_count_tick(ack_count_tick), .default_comms_indicator(default_comms_indicator));

    cds_button_model btn (.hclk(hclk), .default_comms_indicator(default_comms_indicator),
                          .toggle_btn(toggle_btn));

    // Free-running 50 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard; the whole sequence needs well under a thousand cycles.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            finish_test;
        end
    end

    task check(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    // One single AHB-Lite word transfer; read data is taken at the data phase's last edge.
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        rd = hrdata;
        repeat (2) @(posedge hclk);
    endtask

    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask

    // Main sequence: power-up defaults, user set, refusals, toggles, upgrade.
    initial begin
        {hresetn, hsel, hwrite, fw_upgrade_done, cyc, errors, cmp_count} = '0;
        {haddr, htrans, hwdata, ticks} = '0;
        hsize = 3'h2;
        first_boot = 1'b1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        check("boot lamp", 1, default_comms_indicator);
        check("boot set", DEF_SET, cfg_now);
        check("stop bits", 2'h1, ch0_stop_bits);
        first_boot <= 1'b0;
        btn.hold(HOLD + 20, took);
        check("hold ok", 1, took >= HOLD);
        check("user lamp", 0, default_comms_indicator);
        $display("test boot done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h00, 32'h0000_0578 | i);
            check("baud code", i, ch0_baud_sel);
        end
        bus(1'b1, 8'h00, 32'h0000_FF1F);
        rchk("node 255", 8'h00, 32'h0000_057F);
        bus(1'b1, 8'h04, 32'h0000_0000);
        rchk("timeout 0", 8'h04, 32'h0000_0032);
        bus(1'b1, 8'h04, 32'h0000_0001);
        rchk("timeout 1", 8'h04, 32'h0000_0001);
        bus(1'b1, 8'h04, 32'h0000_FFFF);
        bus(1'b1, 8'h08, 32'h0000_0A07);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h10, 32'h0000_0000);
        rchk("status", 8'h0C, 32'h0000_0002);
        check("user set", USR_SET, cfg_now);
        $display("test registers done");
        repeat (100) @(posedge hclk) ticks += int'(ack_count_tick === 1'b1);
        check("ticks", 10, ticks);
        // Read the hold flag while a short press is in progress.
        fork
            btn.tap(HOLD / 2);
            begin
                repeat (4) @(posedge hclk);
                rchk("status hold", 8'h0C, 32'h0000_0006);
            end
        join
        check("short lamp", 0, default_comms_indicator);
        check("short set", USR_SET, cfg_now);
        btn.hold(HOLD + 20, took);
        check("restart", 1, took >= HOLD);
        check("to default", 1, default_comms_indicator);
        check("def set", DEF_SET, cfg_now);
        btn.hold(HOLD + 20, took);
        check("back lamp", 0, default_comms_indicator);
        check("back set", USR_SET, cfg_now);
        $display("test toggle done");
        fw_upgrade_done <= 1'b1;
        repeat (4) @(posedge hclk);
        fw_upgrade_done <= 1'b0;
        repeat (8) @(posedge hclk);
        check("upgrade lamp", 1, default_comms_indicator);
        check("upgrade set", DEF_SET, cfg_now);
        rchk("status def", 8'h0C, 32'h0000_0003);
        bus(1'b1, 8'h0C, 32'h0000_0002);
        rchk("status clr", 8'h0C, 32'h0000_0001);
        $display("test upgrade done");
        // A second reset with the strap low must leave the user set selected.
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        check("reset lamp", 0, default_comms_indicator);
        check("reset set", DEF_SET, cfg_now);
        rchk("reset cfg", 8'h00, 32'h0000_0186);
        $display("test reset done");
        finish_test;
    end
endmodule
